// ### verilog/bcs_control.v
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "bcs_defs.vh"
module bcs_control #(
    parameter [21:0] PIN_G1_CYC = `BCS_MS_CYC(`BCS_PIN_G1_MS),
    parameter [21:0] PIN_G2_CYC = `BCS_MS_CYC(`BCS_PIN_G2_MS),
    parameter [21:0] PIN_G3_CYC = `BCS_MS_CYC(`BCS_PIN_G3_MS)
) (
    input  wire        clock,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        chip_enable_pin,
    input  wire        vout_above_pg_rise,
    input  wire        vout_below_pg_down,
    input  wire        vout_above_high,
    input  wire        vout_above_ov,
    input  wire        vout_below_uv,
    input  wire        current_limit,
    input  wire        thermal_warn_in,
    input  wire        thermal_crit_in,
    input  wire        load_high,
    input  wire [2:0]  pin_in,
    output wire [2:0]  pin_out,
    output wire [2:0]  pin_oe,
    output reg  [7:0]  vout_code,
    output reg         regulator_on,
    output reg  [1:0]  active_mode,
    output reg         pulldown_enable,
    output reg         transition_active,
    output reg         interrupt_out_n
);
    localparam [1:0] ST_OFF   = 2'd0;
    localparam [1:0] ST_START = 2'd1;
    localparam [1:0] ST_RUN   = 2'd2;
    localparam [1:0] ST_SHDN  = 2'd3;
    // timing counts cut to the counter widths on purpose
    localparam integer STEP_MIN_I = `BCS_STEP_MIN_CYC;
    localparam integer OV_CYC_I   = `BCS_OV_GLITCH_CYC;
    localparam integer PIN_G0_I   = `BCS_PIN_G0_CYC;
    localparam [8:0]   STEP_MIN   = STEP_MIN_I[8:0];
    localparam [8:0]   OV_CYC     = OV_CYC_I[8:0];
    localparam [21:0]  PIN_G0_CYC = PIN_G0_I[21:0];

    reg                 en_reg;
    reg                 vsel_reg;
    reg                 vsrc_reg;
    reg                 pd_dis_reg;
    reg                 oc_rmask_reg;
    reg  [2:0]          dvc_sr_reg;
    reg  [2:0]          su_sr_reg;
    reg  [2:0]          sd_sr_reg;
    reg  [7:0]          vout_a_reg;
    reg  [7:0]          vout_b_reg;
    reg  [7:0]          ceil_reg;
    reg  [3:0]          mode_reg;
    reg  [`BCS_EV_W-1:0] event_reg;
    reg  [`BCS_EV_W-1:0] event_next;
    reg  [`BCS_MK_W-1:0] mask_reg;
    reg  [23:0]         pin_cfg_reg;
    reg  [1:0]          state_reg;
    reg  [8:0]          step_cnt_reg;
    reg                 pg_reg;
    reg                 twarn_reg;
    reg                 tcrit_reg;
    reg                 ov_filt_reg;
    reg  [8:0]          ov_cnt_reg;
    reg                 oc_last_reg;
    reg                 uv_last_reg;

    // step interval in cycles for a slew code
    function [8:0] step_len;
        input [2:0] sel;
        begin
            case (sel)
                3'd0:    step_len = STEP_MIN * 9'd16;
                3'd1:    step_len = STEP_MIN * 9'd8;
                3'd2:    step_len = STEP_MIN * 9'd4;
                3'd3:    step_len = STEP_MIN * 9'd2;
                default: step_len = STEP_MIN;
            endcase
        end
    endfunction

    // apb decode, zero wait state
    wire acc    = psel & penable;
    wire wr     = acc & pwrite;
    wire mapped = (paddr == `BCS_OFS_CTRL) || (paddr == `BCS_OFS_VOUT_A) ||
                  (paddr == `BCS_OFS_VOUT_B) || (paddr == `BCS_OFS_CEIL) ||
                  (paddr == `BCS_OFS_MODE) || (paddr == `BCS_OFS_STATUS) ||
                  (paddr == `BCS_OFS_EVENT) || (paddr == `BCS_OFS_MASK) ||
                  (paddr == `BCS_OFS_PIN);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // pin select input; lowest pin in select function wins
    reg pin_vsel;
    integer k;
    always @* begin
        pin_vsel = 1'b0;
        for (k = 2; k >= 0; k = k - 1) begin
            if (pin_cfg_reg[8*k +: 4] == `BCS_PF_VSEL) begin
                pin_vsel = pin_in[k];
            end
        end
    end

    // selected setting and ceiling clamp
    wire use_b    = vsrc_reg ? pin_vsel : vsel_reg;
    wire [7:0] sel_code = use_b ? vout_b_reg : vout_a_reg;
    wire [7:0] target = (sel_code > ceil_reg) ? ceil_reg : sel_code;
    wire go = en_reg & chip_enable_pin & ~thermal_crit_in;

    // ramp goal and rate by state
    wire [7:0] goal = (state_reg == ST_SHDN) ? 8'h00 : target;
    reg  [2:0] rate;
    always @* begin
        case (state_reg)
            ST_START: rate = su_sr_reg;
            ST_SHDN:  rate = sd_sr_reg - 3'd1;
            default:  rate = dvc_sr_reg;
        endcase
    end
    wire ramping = (state_reg != ST_OFF) && (vout_code != goal);
    wire tick    = ramping && (step_cnt_reg >= step_len(rate) - 9'd1);
    wire in_dvc  = (state_reg == ST_RUN) && (vout_code != target);

    // enable, soft start, transitions and shutdown sequencing
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= ST_OFF;
            vout_code    <= 8'h00;
            step_cnt_reg <= 9'h000;
        end else if (!chip_enable_pin || thermal_crit_in) begin
            state_reg    <= ST_OFF;
            vout_code    <= 8'h00;
            step_cnt_reg <= 9'h000;
        end else begin
            step_cnt_reg <= (ramping && !tick) ? step_cnt_reg + 9'd1 : 9'h000;
            if (tick) begin
                vout_code <= (vout_code < goal) ? vout_code + 8'd1
                                                : vout_code - 8'd1;
            end
            case (state_reg)
                ST_OFF: begin
                    if (go) begin
                        state_reg <= ST_START;
                    end
                end
                ST_START, ST_RUN: begin
                    if (!go) begin
                        if (sd_sr_reg == 3'd0) begin
                            state_reg <= ST_OFF;
                            vout_code <= 8'h00;
                        end else begin
                            state_reg <= ST_SHDN;
                        end
                    end else if (state_reg == ST_START && vout_code == target) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_SHDN: begin
                    if (go) begin
                        state_reg <= ST_START;
                    end else if (vout_code == 8'h00) begin
                        state_reg <= ST_OFF;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // operating mode, pull-down and run indicators
    wire [1:0] cfg_mode = use_b ? mode_reg[3:2] : mode_reg[1:0];
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            active_mode       <= `BCS_MODE_OFF;
            pulldown_enable   <= 1'b1;
            regulator_on      <= 1'b0;
            transition_active <= 1'b0;
        end else begin
            pulldown_enable   <= ~chip_enable_pin | ~pd_dis_reg;
            regulator_on      <= (state_reg != ST_OFF);
            transition_active <= in_dvc;
            if (state_reg == ST_OFF) begin
                active_mode <= `BCS_MODE_OFF;
            end else if (in_dvc || cfg_mode == `BCS_MODE_PWM) begin
                active_mode <= `BCS_MODE_PWM;
            end else if (cfg_mode == `BCS_MODE_AUTO) begin
                active_mode <= load_high ? `BCS_MODE_PWM : `BCS_MODE_PFM;
            end else begin
                active_mode <= `BCS_MODE_PFM;
            end
        end
    end

    // power good, thermal status, over-voltage deglitch
    wire pg_fail = vout_below_pg_down | vout_above_high;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pg_reg      <= 1'b0;
            twarn_reg   <= 1'b0;
            tcrit_reg   <= 1'b0;
            ov_filt_reg <= 1'b0;
            ov_cnt_reg  <= 9'h000;
            oc_last_reg <= 1'b0;
            uv_last_reg <= 1'b0;
        end else begin
            if (state_reg == ST_OFF || pg_fail) begin
                pg_reg <= 1'b0;
            end else if (vout_above_pg_rise) begin
                pg_reg <= 1'b1;
            end
            twarn_reg   <= thermal_warn_in;
            tcrit_reg   <= thermal_crit_in;
            oc_last_reg <= current_limit;
            uv_last_reg <= vout_below_uv;
            if (vout_above_ov == ov_filt_reg) begin
                ov_cnt_reg <= 9'h000;
            end else if (ov_cnt_reg >= OV_CYC - 9'd1) begin
                ov_filt_reg <= vout_above_ov;
                ov_cnt_reg  <= 9'h000;
            end else begin
                ov_cnt_reg <= ov_cnt_reg + 9'd1;
            end
        end
    end

    // per-pin deglitch and change detect
    wire [2:0] pin_set;
    wire [2:0] pin_drv;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_pin
            wire [3:0]  fn   = pin_cfg_reg[8*g +: 4];
            wire [1:0]  trig = pin_cfg_reg[8*g+4 +: 2];
            wire [1:0]  dsel = pin_cfg_reg[8*g+6 +: 2];
            wire [21:0] len  = (dsel == 2'd0) ? PIN_G0_CYC :
                               (dsel == 2'd1) ? PIN_G1_CYC :
                               (dsel == 2'd2) ? PIN_G2_CYC : PIN_G3_CYC;
            reg         stable_reg;
            reg  [21:0] cnt_reg;
            reg         chg_reg;
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    stable_reg <= 1'b0;
                    cnt_reg    <= 22'h000000;
                    chg_reg    <= 1'b0;
                end else begin
                    chg_reg <= 1'b0;
                    if (pin_in[g] == stable_reg) begin
                        cnt_reg <= 22'h000000;
                    end else if (cnt_reg >= len - 22'd1) begin
                        stable_reg <= pin_in[g];
                        cnt_reg    <= 22'h000000;
                        case (trig)
                            `BCS_TRIG_RISE: chg_reg <= pin_in[g];
                            `BCS_TRIG_FALL: chg_reg <= ~pin_in[g];
                            `BCS_TRIG_BOTH: chg_reg <= 1'b1;
                            default:        chg_reg <= 1'b0;
                        endcase
                    end else begin
                        cnt_reg <= cnt_reg + 22'd1;
                    end
                end
            end
            assign pin_set[g] = chg_reg;
            assign pin_drv[g] = (fn == `BCS_PF_PG)   ? pg_reg :
                                (fn == `BCS_PF_IRQ)  ? interrupt_out_n :
                                (fn == `BCS_PF_HIGH) ? 1'b1 : 1'b0;
            assign pin_oe[g]  = fn[3] & (fn != `BCS_PF_HIZ);
        end
    endgenerate
    assign pin_out = pin_drv;

    // event sources; set wins over a clearing write
    reg [`BCS_EV_W-1:0] ev_set;
    always @* begin
        ev_set = {`BCS_EV_W{1'b0}};
        ev_set[`BCS_EV_TWARN] = thermal_warn_in & ~twarn_reg;
        ev_set[`BCS_EV_TCRIT] = thermal_crit_in & ~tcrit_reg;
        ev_set[`BCS_EV_PG]    = (state_reg != ST_OFF) & ~pg_fail &
                                vout_above_pg_rise & ~pg_reg;
        ev_set[`BCS_EV_OV]    = (ov_cnt_reg >= OV_CYC - 9'd1) &
                                vout_above_ov & ~ov_filt_reg;
        ev_set[`BCS_EV_UV]    = vout_below_uv & ~uv_last_reg;
        ev_set[`BCS_EV_OC]    = current_limit & ~oc_last_reg &
                                ~(oc_rmask_reg & in_dvc);
        ev_set[`BCS_EV_PIN0 +: 3] = pin_set;
        event_next = event_reg | ev_set;
        if (wr && paddr == `BCS_OFS_EVENT) begin
            event_next = (event_reg & ~pwdata[`BCS_EV_W-1:0]) | ev_set;
        end
    end

    // interrupt combine of events and live status
    wire irq = |(event_reg & ~mask_reg[`BCS_EV_W-1:0]) |
               (pg_reg & ~mask_reg[`BCS_MK_PGSTAT]) |
               (twarn_reg & ~mask_reg[`BCS_MK_WARNSTAT]);
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            event_reg       <= {`BCS_EV_W{1'b0}};
            interrupt_out_n <= 1'b1;
        end else if (!chip_enable_pin) begin
            event_reg       <= {`BCS_EV_W{1'b0}};
            interrupt_out_n <= 1'b1;
        end else begin
            event_reg       <= event_next;
            interrupt_out_n <= ~irq;
        end
    end

    // register writes
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            en_reg       <= 1'b0;
            vsel_reg     <= 1'b0;
            vsrc_reg     <= 1'b0;
            pd_dis_reg   <= 1'b0;
            oc_rmask_reg <= 1'b0;
            dvc_sr_reg   <= 3'h0;
            su_sr_reg    <= 3'h0;
            sd_sr_reg    <= 3'h0;
            vout_a_reg   <= `BCS_RST_VOUT_A;
            vout_b_reg   <= `BCS_RST_VOUT_B;
            ceil_reg     <= `BCS_RST_CEIL;
            mode_reg     <= 4'h0;
            mask_reg     <= `BCS_RST_MASK;
            pin_cfg_reg  <= 24'h000000;
        end else if (wr) begin
            case (paddr)
                `BCS_OFS_CTRL: begin
                    en_reg       <= pwdata[`BCS_CTRL_EN];
                    vsel_reg     <= pwdata[`BCS_CTRL_VSEL];
                    vsrc_reg     <= pwdata[`BCS_CTRL_VSRC];
                    pd_dis_reg   <= pwdata[`BCS_CTRL_PDDIS];
                    dvc_sr_reg   <= pwdata[`BCS_CTRL_DVC_LO +: 3];
                    su_sr_reg    <= pwdata[`BCS_CTRL_SU_LO +: 3];
                    sd_sr_reg    <= pwdata[`BCS_CTRL_SD_LO +: 3];
                    oc_rmask_reg <= pwdata[`BCS_CTRL_OCRM];
                end
                `BCS_OFS_VOUT_A: vout_a_reg <= pwdata[7:0];
                `BCS_OFS_VOUT_B: vout_b_reg <= pwdata[7:0];
                `BCS_OFS_CEIL:   ceil_reg   <= pwdata[7:0];
                `BCS_OFS_MODE:   mode_reg   <= pwdata[3:0];
                `BCS_OFS_MASK:   mask_reg   <= pwdata[`BCS_MK_W-1:0];
                `BCS_OFS_PIN:    pin_cfg_reg <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `BCS_OFS_CTRL:   prdata <= {15'h0000, oc_rmask_reg, 1'b0,
                                            sd_sr_reg, 1'b0, su_sr_reg, 1'b0,
                                            dvc_sr_reg, pd_dis_reg, vsrc_reg,
                                            vsel_reg, en_reg};
                `BCS_OFS_VOUT_A: prdata <= {24'h000000, vout_a_reg};
                `BCS_OFS_VOUT_B: prdata <= {24'h000000, vout_b_reg};
                `BCS_OFS_CEIL:   prdata <= {24'h000000, ceil_reg};
                `BCS_OFS_MODE:   prdata <= {28'h0000000, mode_reg};
                `BCS_OFS_STATUS: prdata <= {16'h0000, vout_code, 3'h0,
                                            regulator_on, transition_active,
                                            tcrit_reg, twarn_reg, pg_reg};
                `BCS_OFS_EVENT:  prdata <= {23'h000000, event_reg};
                `BCS_OFS_MASK:   prdata <= {21'h000000, mask_reg};
                `BCS_OFS_PIN:    prdata <= {8'h00, pin_cfg_reg};
                default:         prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ### shared/bcs_defs.vh
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH
// clock and timing
`define BCS_CLK_MHZ        40
`define BCS_STEP_MIN_NS    500
`define BCS_STEP_MIN_CYC   ((`BCS_STEP_MIN_NS * `BCS_CLK_MHZ) / 1000)
`define BCS_OV_GLITCH_US   8
`define BCS_OV_GLITCH_CYC  (`BCS_OV_GLITCH_US * `BCS_CLK_MHZ)
`define BCS_PIN_G0_US      100
`define BCS_PIN_G0_CYC     (`BCS_PIN_G0_US * `BCS_CLK_MHZ)
`define BCS_PIN_G1_MS      1
`define BCS_PIN_G2_MS      10
`define BCS_PIN_G3_MS      100
`define BCS_MS_CYC(ms)     ((ms) * `BCS_CLK_MHZ * 1000)
// register byte offsets
`define BCS_OFS_CTRL       8'h00
`define BCS_OFS_VOUT_A     8'h04
`define BCS_OFS_VOUT_B     8'h08
`define BCS_OFS_CEIL       8'h0C
`define BCS_OFS_MODE       8'h10
`define BCS_OFS_STATUS     8'h14
`define BCS_OFS_EVENT      8'h18
`define BCS_OFS_MASK       8'h1C
`define BCS_OFS_PIN        8'h20
// control register fields
`define BCS_CTRL_EN        0
`define BCS_CTRL_VSEL      1
`define BCS_CTRL_VSRC      2
`define BCS_CTRL_PDDIS     3
`define BCS_CTRL_DVC_LO    4
`define BCS_CTRL_SU_LO     8
`define BCS_CTRL_SD_LO     12
`define BCS_CTRL_OCRM      16
// event and mask bit positions
`define BCS_EV_TWARN       0
`define BCS_EV_TCRIT       1
`define BCS_EV_PG          2
`define BCS_EV_OV          3
`define BCS_EV_UV          4
`define BCS_EV_OC          5
`define BCS_EV_PIN0        6
`define BCS_EV_W           9
`define BCS_MK_PGSTAT      9
`define BCS_MK_WARNSTAT    10
`define BCS_MK_W           11
// reset values
`define BCS_RST_VOUT_A     8'h46
`define BCS_RST_VOUT_B     8'h32
`define BCS_RST_CEIL       8'hFF
`define BCS_RST_MASK       11'h000
// operating modes
`define BCS_MODE_AUTO      2'h0
`define BCS_MODE_PWM       2'h1
`define BCS_MODE_PFM       2'h2
`define BCS_MODE_OFF       2'h0
// pin functions
`define BCS_PF_VSEL        4'h4
`define BCS_PF_PG          4'h8
`define BCS_PF_IRQ         4'hC
`define BCS_PF_HIZ         4'hD
`define BCS_PF_LOW         4'hE
`define BCS_PF_HIGH        4'hF
// pin trigger codes
`define BCS_TRIG_RISE      2'h0
`define BCS_TRIG_FALL      2'h1
`define BCS_TRIG_BOTH      2'h2
`endif

// ### dv/bcs_control_assertions.sv
`timescale 1ns/10ps
`include "bcs_defs.vh"
module bcs_control_chk (
    input wire       clock,
    input wire       resetn,
    input wire       psel,
    input wire       penable,
    input wire [7:0] paddr,
    input wire       pready,
    input wire       pslverr,
    input wire       chip_enable_pin,
    input wire       thermal_crit_in,
    input wire [7:0] vout_code,
    input wire       regulator_on,
    input wire [1:0] active_mode,
    input wire       pulldown_enable,
    input wire       transition_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // chip held off for two edges
    sequence s_off_two;
        !chip_enable_pin [*2];
    endsequence
    sequence s_step;
        vout_code != $past(vout_code) && vout_code != 8'h00;
    endsequence
    property p_ready; pready; endproperty
    property p_slverr; psel && penable && paddr > 8'h20 |-> pslverr; endproperty
    property p_pd_off; !chip_enable_pin |=> pulldown_enable; endproperty
    property p_off_code; s_off_two |=> vout_code == 8'h00 && !regulator_on; endproperty
    property p_crit; thermal_crit_in |=> vout_code == 8'h00; endproperty
    property p_step_size;
        s_step |-> vout_code - $past(vout_code) == 8'h01 || $past(vout_code) - vout_code == 8'h01;
    endproperty
    property p_step_gap;
        s_step |=> (vout_code == $past(vout_code) || vout_code == 8'h00) [*8];
    endproperty
    property p_pwm;
        transition_active && $past(transition_active) |-> active_mode == `BCS_MODE_PWM;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_slverr: assert property (p_slverr) else $error("no slave error");
    a_pd_off: assert property (p_pd_off) else $error("pull-down off");
    a_off_code: assert property (p_off_code) else $error("not off");
    a_crit: assert property (p_crit) else $error("no critical shutdown");
    a_step_size: assert property (p_step_size) else $error("step size");
    a_step_gap: assert property (p_step_gap) else $error("step gap");
    a_pwm: assert property (p_pwm) else $error("not pwm in ramp");
endmodule
bind bcs_control bcs_control_chk u_chk (.*);

// ### dv/bcs_plant.sv
`timescale 1ns/10ps
module bcs_plant (
    input wire        regulator_on,
    input wire  [7:0] vout_code,
    input wire  [7:0] ref_code,
    input wire  [2:0] pin_out,
    input wire  [2:0] pin_oe,
    input wire  [2:0] host_pins,
    output wire       vout_above_pg_rise,
    output wire       vout_below_pg_down,
    output wire       vout_above_high,
    output wire       vout_above_ov,
    output wire       vout_below_uv,
    output wire [2:0] pin_in
);
    // output follows the code; window around the expected target
    assign vout_above_pg_rise = regulator_on && vout_code + 8'h02 >= ref_code;
    assign vout_below_pg_down = vout_code + 8'h04 < ref_code;
    assign vout_above_high = vout_code > ref_code + 8'h0F;
    assign vout_above_ov = vout_code > ref_code + 8'h0F;
    assign vout_below_uv = vout_code + 8'h04 < ref_code;
    // host drives pins the device leaves free
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_pins);
endmodule

// ### dv/tb.sv
`timescale 1ns/10ps
`include "bcs_defs.vh"
module tb;
    logic        clock, resetn, psel, penable, pwrite, pready, pslverr, serr;
    logic        chip_enable_pin, current_limit, thermal_warn_in, thermal_crit_in, load_high;
    logic        vout_above_pg_rise, vout_below_pg_down, vout_above_high, vout_above_ov;
    logic        vout_below_uv, regulator_on, pulldown_enable, transition_active;
    logic        interrupt_out_n;
    logic [1:0]  active_mode;
    logic [2:0]  pin_in, pin_out, pin_oe, host_pins;
    logic [7:0]  paddr, vout_code, ref_code, va;
    logic [31:0] pwdata, prdata, q;
    integer      seed, err_total, cmp_count, i, k;
    bcs_control dut (.*);
    bcs_plant u_plant (.*);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    function logic [7:0] tgt(input logic [7:0] s, input logic [7:0] c);
        tgt = s < c ? s : c;
    endfunction
    function logic [1:0] exp_mode(input logic l);
        exp_mode = l ? `BCS_MODE_PWM : `BCS_MODE_PFM;
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_code(input logic [7:0] e);
        ref_code <= e;
        for (i = 0; i < 5000 && vout_code !== e; i = i + 1) @(posedge clock);
        chk("vout_code", {24'h0, e}, {24'h0, vout_code});
    endtask
    task wrap_up;
        if (err_total == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        err_total = err_total + 1;
        wrap_up;
    end
    initial begin
        {seed, err_total, cmp_count} = {32'hA03F, 64'h0};
        {resetn, psel, penable, pwrite, paddr, pwdata, ref_code, host_pins} = '0;
        {chip_enable_pin, current_limit, thermal_warn_in, thermal_crit_in, load_high} = 5'h10;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        apb(0, `BCS_OFS_VOUT_A, 0);
        chk("vout_a", 32'h46, q);
        apb(0, `BCS_OFS_CEIL, 0);
        chk("ceiling", 32'hFF, q);
        apb(0, 8'h24, 0);
        chk("unmapped", 32'h1, {q[31:1], serr});
        va = 8'h10 + 8'($random(seed) & 32'h1F);
        apb(1, `BCS_OFS_CEIL, 32'h40);
        apb(1, `BCS_OFS_VOUT_A, {24'h0, va});
        apb(1, `BCS_OFS_CTRL, 32'h441);
        wait_code(tgt(va, 8'h40));
        apb(1, `BCS_OFS_PIN, 32'h08);
        @(posedge clock);
        chk("pg_pin", 32'h3, {30'h0, pin_oe[0], pin_out[0]});
        apb(0, `BCS_OFS_STATUS, 0);
        chk("status", {16'h0, va, 8'h11}, q);
        apb(1, `BCS_OFS_VOUT_A, 32'h5A);
        wait_code(tgt(8'h5A, 8'h40));
        apb(1, `BCS_OFS_CTRL, 32'h10443);
        current_limit <= 1'b1;
        repeat (3) @(posedge clock);
        current_limit <= 1'b0;
        apb(0, `BCS_OFS_EVENT, 0);
        chk("oc_ramp", 32'h0, q & 32'h20);
        wait_code(tgt(`BCS_RST_VOUT_B, 8'h40));
        apb(1, `BCS_OFS_PIN, 32'h408);
        apb(1, `BCS_OFS_CTRL, 32'h10445);
        wait_code(tgt(8'h5A, 8'h40));
        host_pins <= 3'h2;
        wait_code(tgt(`BCS_RST_VOUT_B, 8'h40));
        load_high <= 1'b1;
        apb(1, `BCS_OFS_MODE, 32'h8);
        repeat (2) @(posedge clock);
        chk("mode", {30'h0, `BCS_MODE_PFM}, {30'h0, active_mode});
        apb(1, `BCS_OFS_MODE, 32'h0);
        for (k = 0; k < 4; k = k + 1) begin
            load_high <= 1'($random(seed));
            repeat (3) @(posedge clock);
            chk("auto", {30'h0, exp_mode(load_high)}, {30'h0, active_mode});
        end
        for (k = 0; k < 2; k = k + 1) begin
            apb(1, `BCS_OFS_MASK, k ? 32'h7FF : 32'h7DF);
            apb(1, `BCS_OFS_EVENT, 32'h1FF);
            current_limit <= 1'b1;
            repeat (3) @(posedge clock);
            current_limit <= 1'b0;
            chk("irq_n", 32'(k), {31'h0, interrupt_out_n});
            apb(0, `BCS_OFS_EVENT, 0);
            chk("oc_event", 32'h20, q & 32'h20);
        end
        // over-voltage held past the deglitch span
        apb(1, `BCS_OFS_EVENT, 32'h1FF);
        ref_code <= 8'h20;
        repeat (300) @(posedge clock);
        apb(0, `BCS_OFS_EVENT, 0);
        chk("ov_early", 32'h0, q & 32'h8);
        repeat (30) @(posedge clock);
        apb(0, `BCS_OFS_EVENT, 0);
        chk("ov_event", 32'h8, q & 32'h8);
        ref_code <= `BCS_RST_VOUT_B;
        apb(1, `BCS_OFS_MASK, 32'h3FF);
        thermal_warn_in <= 1'b1;
        repeat (3) @(posedge clock);
        apb(0, `BCS_OFS_STATUS, 0);
        chk("warn", 32'h2, q & 32'h6);
        chk("warn_irq", 32'h0, {31'h0, interrupt_out_n});
        thermal_crit_in <= 1'b1;
        repeat (3) @(posedge clock);
        apb(0, `BCS_OFS_STATUS, 0);
        chk("crit", 32'h6, q & 32'h6);
        {thermal_warn_in, thermal_crit_in} <= 2'h0;
        repeat (3) @(posedge clock);
        apb(0, `BCS_OFS_STATUS, 0);
        chk("clear", 32'h0, q & 32'h6);
        chk("warn_irq_off", 32'h1, {31'h0, interrupt_out_n});
        apb(1, `BCS_OFS_CTRL, 32'h44B);
        repeat (2) @(posedge clock);
        chk("pd_dis", 32'h0, {31'h0, pulldown_enable});
        chip_enable_pin <= 1'b0;
        repeat (3) @(posedge clock);
        chk("pd_off", 32'h1, {31'h0, pulldown_enable});
        chip_enable_pin <= 1'b1;
        wait_code(tgt(`BCS_RST_VOUT_B, 8'h40));
        apb(1, `BCS_OFS_CTRL, 32'h440);
        repeat (2) @(posedge clock);
        chk("shutdown", 32'h0, {24'h0, vout_code});
        wrap_up;
    end
endmodule
